//--- hdl/lfc_pkg.sv
// Constants and carrier types for the loop-filter capacitor registers.
// Assumes a 32-bit AXI4-Lite master and one 40 MHz system clock.
package lfc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // Register indices as printed; byte address is four times the index
    localparam logic [ADDR_W-3:0] IDX_CAP_ONE = 10'h05c;
    localparam logic [ADDR_W-3:0] IDX_CAP_TWO = 10'h05d;
    // Field layout of each 8-bit register
    localparam int UNIMPL_BIT = 7;
    localparam int TRIM_MSB = 6;
    localparam int TRIM_LSB = 5;
    localparam int CODE_MSB = 4;
    localparam int CODE_LSB = 0;
    localparam int REG_W = 8;
    // Power-on values
    localparam logic [1:0] TRIM_RST = 2'h1;
    localparam logic [4:0] CODE_RST = 5'h07;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Stored part of one register, bits 6 down to 0
    typedef struct packed {
        logic [1:0] factory_trim_bits;
        logic [4:0] code;
    } lfc_capreg_t;

    // Settings that go to the analog loop filter
    typedef struct packed {
        logic [1:0] trim_first;
        logic [4:0] loop_cap_first_code;
        logic [1:0] trim_second;
        logic [4:0] loop_cap_second_code;
    } lfc_caps_t;

    localparam lfc_capreg_t CAPREG_RST = '{factory_trim_bits: TRIM_RST, code: CODE_RST};
endpackage

//--- hdl/lfc_regs.sv
// Two loop-filter capacitor code registers behind an AXI4-Lite slave.
// Assumes a master that keeps at most one write and one read under way.
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

// Behaviour
// R1: Bit 7 of both registers reads zero; writes to it are ignored.
// R2: Trim bits 6:5 reset to 0 and 1; host writes them back unchanged.
// R3: Index 0x5C holds first capacitor code in bits 4:0, reset 00111.
// R4: Index 0x5D holds second capacitor code in bits 4:0, reset 00111.
// R5: Codes are unsigned; larger code means linearly larger capacitance.
// R6: Host picks both codes from the phase detector comparison frequency.
// R7: Reads return last written code and trim bits, reset values before.
module lfc_regs (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic [lfc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [lfc_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [lfc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [lfc_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output lfc_pkg::lfc_caps_t CAP_CFG
);

    lfc_pkg::lfc_capreg_t cap1_r;
    lfc_pkg::lfc_capreg_t cap2_r;
    logic aw_held_r;
    logic [lfc_pkg::ADDR_W-1:0] awaddr_r;
    logic w_held_r;
    logic [lfc_pkg::DATA_W-1:0] wdata_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [lfc_pkg::DATA_W-1:0] rdata_r;
    logic [lfc_pkg::DATA_W-1:0] rdata_nxt;

    wire aw_take = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take = S_AXI_WVALID && S_AXI_WREADY;
    wire ar_take = S_AXI_ARVALID && S_AXI_ARREADY;

    // Write side: address and data may arrive in either order
    wire aw_have = aw_held_r || aw_take;
    wire w_have = w_held_r || w_take;
    wire do_wr = aw_have && w_have && !bvalid_r;
    wire [lfc_pkg::ADDR_W-1:0] wr_addr = aw_held_r ? awaddr_r : S_AXI_AWADDR;
    wire [lfc_pkg::DATA_W-1:0] wr_data = w_held_r ? wdata_r : S_AXI_WDATA;
    wire wr_lane0 = w_held_r ? wstrb0_r : S_AXI_WSTRB[0];
    wire [lfc_pkg::ADDR_W-3:0] wr_idx = wr_addr[lfc_pkg::ADDR_W-1:2];
    wire wr_hit1 = (wr_idx == lfc_pkg::IDX_CAP_ONE);
    wire wr_hit2 = (wr_idx == lfc_pkg::IDX_CAP_TWO);
    wire wr_hit = wr_hit1 || wr_hit2;
    // R1: bit 7 dropped
    wire lfc_pkg::lfc_capreg_t wr_val = wr_data[lfc_pkg::TRIM_MSB:lfc_pkg::CODE_LSB];
    wire wr_en1 = do_wr && wr_hit1 && wr_lane0;
    wire wr_en2 = do_wr && wr_hit2 && wr_lane0;

    // Read side decode
    wire [lfc_pkg::ADDR_W-3:0] rd_idx = S_AXI_ARADDR[lfc_pkg::ADDR_W-1:2];
    wire rd_hit1 = (rd_idx == lfc_pkg::IDX_CAP_ONE);
    wire rd_hit2 = (rd_idx == lfc_pkg::IDX_CAP_TWO);

    // Handshake outputs
    assign S_AXI_AWREADY = !aw_held_r && !bvalid_r;
    assign S_AXI_WREADY = !w_held_r && !bvalid_r;
    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = rdata_r;

    // R1: unimplemented bit and upper bits read zero
    always_comb begin
        rdata_nxt = '0;
        if (rd_hit1) begin
            rdata_nxt[lfc_pkg::TRIM_MSB:lfc_pkg::CODE_LSB] = cap1_r;
        end else if (rd_hit2) begin
            rdata_nxt[lfc_pkg::TRIM_MSB:lfc_pkg::CODE_LSB] = cap2_r;
        end
    end

    // R5: codes leave as unsigned magnitudes to the filter
    assign CAP_CFG.trim_first = cap1_r.factory_trim_bits;
    assign CAP_CFG.loop_cap_first_code = cap1_r.code;
    assign CAP_CFG.trim_second = cap2_r.factory_trim_bits;
    assign CAP_CFG.loop_cap_second_code = cap2_r.code;

    // R2: trim bits reset to 0 and 1 and keep what is written
    // R3: first code resets to 00111
    // R4: second code resets to 00111
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            cap1_r <= lfc_pkg::CAPREG_RST;
            cap2_r <= lfc_pkg::CAPREG_RST;
        end else begin
            if (wr_en1) begin
                cap1_r <= wr_val;
            end
            if (wr_en2) begin
                cap2_r <= wr_val;
            end
        end
    end

    // Holding of write address and data until both are present
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb0_r <= 1'b0;
        end else begin
            if (aw_take) begin
                awaddr_r <= S_AXI_AWADDR;
            end
            if (w_take) begin
                wdata_r <= S_AXI_WDATA;
                wstrb0_r <= S_AXI_WSTRB[0];
            end
            aw_held_r <= aw_have && !do_wr;
            w_held_r <= w_have && !do_wr;
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            bvalid_r <= 1'b0;
            bresp_r <= lfc_pkg::RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? lfc_pkg::RESP_OKAY : lfc_pkg::RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    // R7: read returns stored values
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            rvalid_r <= 1'b0;
            rresp_r <= lfc_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rdata_nxt;
            rresp_r <= (rd_hit1 || rd_hit2) ? lfc_pkg::RESP_OKAY : lfc_pkg::RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_wr_taken;
        do_wr && wr_hit1 && wr_lane0;
    endsequence

    sequence s_rd_first;
        ar_take && rd_hit1;
    endsequence

    sequence s_wr_second;
        do_wr && wr_hit2 && wr_lane0;
    endsequence

    sequence s_rd_second;
        ar_take && rd_hit2;
    endsequence

    sequence s_wr_unmapped;
        do_wr && !wr_hit;
    endsequence

    sequence s_wr_no_lane;
        do_wr && wr_hit && !wr_lane0;
    endsequence

    sequence s_rd_unmapped;
        ar_take && !rd_hit1 && !rd_hit2;
    endsequence

    sequence s_bresp_waiting;
        S_AXI_BVALID && !S_AXI_BREADY;
    endsequence

    sequence s_rresp_waiting;
        S_AXI_RVALID && !S_AXI_RREADY;
    endsequence

    a_unimpl_reads_zero: assert property ( // R1
        S_AXI_RVALID |-> S_AXI_RDATA[lfc_pkg::DATA_W-1:lfc_pkg::UNIMPL_BIT] == '0)
        else $error("Read data above bit 6 not zero");

    a_trim_after_reset: assert property ( // R2
        $rose(RST_N) |-> cap1_r.factory_trim_bits == lfc_pkg::TRIM_RST
            && cap2_r.factory_trim_bits == lfc_pkg::TRIM_RST)
        else $error("Trim bits wrong after reset");

    a_first_code_reset: assert property ( // R3
        $rose(RST_N) |-> CAP_CFG.loop_cap_first_code == lfc_pkg::CODE_RST)
        else $error("First code wrong after reset");

    a_second_code_reset: assert property ( // R4
        $rose(RST_N) |-> CAP_CFG.loop_cap_second_code == lfc_pkg::CODE_RST)
        else $error("Second code wrong after reset");

    a_code_out_follows: assert property ( // R5
        s_wr_taken |=> CAP_CFG.loop_cap_first_code == $past(wr_data[lfc_pkg::CODE_MSB:lfc_pkg::CODE_LSB]))
        else $error("First code output did not take written value");

    a_write_then_ack: assert property ( // R7
        s_wr_taken |=> S_AXI_BVALID && S_AXI_BRESP == lfc_pkg::RESP_OKAY
            && cap1_r == $past(wr_val))
        else $error("Write not stored or not acknowledged");

    a_read_returns_value: assert property ( // R7
        s_rd_first |=> S_AXI_RVALID && S_AXI_RDATA[lfc_pkg::TRIM_MSB:lfc_pkg::CODE_LSB] == $past(cap1_r))
        else $error("Read did not return stored first register");

    a_second_untouched: assert property ( // R7
        !wr_en2 |=> $stable(cap2_r))
        else $error("Second register changed without a write");

    a_second_code_follows: assert property ( // R5
        s_wr_second |=> CAP_CFG.loop_cap_second_code == $past(wr_data[lfc_pkg::CODE_MSB:lfc_pkg::CODE_LSB]))
        else $error("Second code output did not take written value");

    a_trim_first_kept: assert property ( // R2
        s_wr_taken |=> cap1_r.factory_trim_bits == $past(wr_data[lfc_pkg::TRIM_MSB:lfc_pkg::TRIM_LSB]))
        else $error("First trim bits did not take written value");

    a_trim_second_kept: assert property ( // R2
        s_wr_second |=> cap2_r.factory_trim_bits == $past(wr_data[lfc_pkg::TRIM_MSB:lfc_pkg::TRIM_LSB]))
        else $error("Second trim bits did not take written value");

    a_second_write_ack: assert property ( // R7
        s_wr_second |=> S_AXI_BVALID && S_AXI_BRESP == lfc_pkg::RESP_OKAY
            && cap2_r == $past(wr_val))
        else $error("Second write not stored or not acknowledged");

    a_read_second_value: assert property ( // R7
        s_rd_second |=> S_AXI_RVALID && S_AXI_RDATA[lfc_pkg::TRIM_MSB:lfc_pkg::CODE_LSB] == $past(cap2_r))
        else $error("Read did not return stored second register");

    a_first_untouched: assert property ( // R7
        !wr_en1 |=> $stable(cap1_r))
        else $error("First register changed without a write");

    a_unmapped_write: assert property ( // R7
        s_wr_unmapped |=> S_AXI_BVALID && S_AXI_BRESP == lfc_pkg::RESP_SLVERR
            && $stable(cap1_r) && $stable(cap2_r))
        else $error("Unmapped write not refused");

    a_lane_off_write: assert property ( // R7
        s_wr_no_lane |=> S_AXI_BVALID && S_AXI_BRESP == lfc_pkg::RESP_OKAY
            && $stable(cap1_r) && $stable(cap2_r))
        else $error("Write without byte lane zero changed a register");

    a_unmapped_read: assert property ( // R7
        s_rd_unmapped |=> S_AXI_RVALID && S_AXI_RRESP == lfc_pkg::RESP_SLVERR
            && S_AXI_RDATA == '0)
        else $error("Unmapped read not refused with zero data");

    a_bresp_stands: assert property ( // R7
        s_bresp_waiting |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("Write response dropped or changed before ready");

    a_rdata_stands: assert property ( // R7
        s_rresp_waiting |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
        else $error("Read response dropped or changed before ready");

    a_bvalid_released: assert property ( // R7
        S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
        else $error("Write response not released after ready");

    a_rvalid_released: assert property ( // R7
        S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("Read response not released after ready");

    a_write_busy_refused: assert property ( // R7
        S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("Write channel ready while response pending");

    a_read_busy_refused: assert property ( // R7
        S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("Read address ready while data pending");

    a_idle_after_reset: assert property ( // R7
        $rose(RST_N) |-> !S_AXI_BVALID && !S_AXI_RVALID
            && S_AXI_AWREADY && S_AXI_WREADY && S_AXI_ARREADY)
        else $error("Bus not idle after reset");

endmodule // lfc_regs

//--- testbench/lfc_regs_test.sv
// Self-checking bench for the loop-filter capacitor register pair.
// Assumes an AXI4-Lite slave; every wait lasts until the answer, and only the watchdog ends it.
`timescale 1ns/1ps
module lfc_regs_test;
    localparam logic [11:0] A_ONE = {lfc_pkg::IDX_CAP_ONE, 2'h0};
    localparam logic [11:0] A_TWO = {lfc_pkg::IDX_CAP_TWO, 2'h0};
    logic clk_sys = 1'h0;
    logic rst_n = 1'h0;
    logic [11:0] awaddr = 12'h0;
    logic [11:0] araddr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    lfc_pkg::lfc_caps_t cap_cfg;
    int fail_count = 0;
    int checked = 0;

    lfc_regs u_dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CAP_CFG(cap_cfg));

    // Free-running 40 MHz clock
    initial forever #12.5 clk_sys = ~clk_sys;

    // Compare one value and count it
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One write: address and data offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        bit aw_ok;
        bit w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        forever begin
            @(posedge clk_sys);
            if (bvalid) break;
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'h0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'h0;
            end
        end
        bready <= 1'h0;
        chk("awready", {31'h0, awready}, 32'h0);
        chk("wready", {31'h0, wready}, 32'h0);
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        @(posedge clk_sys);
    endtask

    // One read, compared with the expected word and response
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        forever begin
            @(posedge clk_sys);
            if (rvalid) break;
            if (arready) arvalid <= 1'h0;
        end
        rready <= 1'h0;
        chk("arready", {31'h0, arready}, 32'h0);
        chk("rdata", rdata, ed);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
        @(posedge clk_sys);
    endtask

    // Expected analog settings from both stored words
    task automatic cfg(input logic [6:0] one, input logic [6:0] two);
        chk("cap_cfg", {18'h0, cap_cfg}, {18'h0, one, two});
    endtask

    task automatic test_reset();
        chk("awready", {31'h0, awready}, 32'h1);
        chk("wready", {31'h0, wready}, 32'h1);
        chk("arready", {31'h0, arready}, 32'h1);
        rd(A_ONE, 32'h27, lfc_pkg::RESP_OKAY);
        rd(A_TWO, 32'h27, lfc_pkg::RESP_OKAY);
        cfg(7'h27, 7'h27);
    endtask

    task automatic test_write_max();
        wr(A_ONE, 32'hffffffbf, 4'h1, lfc_pkg::RESP_OKAY);
        cfg(7'h3f, 7'h27);
        rd(A_ONE, 32'h3f, lfc_pkg::RESP_OKAY);
    endtask

    task automatic test_write_min();
        wr(A_TWO, 32'h20, 4'h1, lfc_pkg::RESP_OKAY);
        cfg(7'h3f, 7'h20);
        rd(A_TWO | 12'h3, 32'h20, lfc_pkg::RESP_OKAY);
        rd(A_ONE, 32'h3f, lfc_pkg::RESP_OKAY);
    endtask

    task automatic test_refused();
        wr(12'h178, 32'h1f, 4'h1, lfc_pkg::RESP_SLVERR);
        rd(12'h178, 32'h0, lfc_pkg::RESP_SLVERR);
        wr(A_ONE, 32'h25, 4'h0, lfc_pkg::RESP_OKAY);
        rd(A_ONE, 32'h3f, lfc_pkg::RESP_OKAY);
        cfg(7'h3f, 7'h20);
    endtask

    // Write and read together; both answers wait for a late ready and stand meanwhile
    task automatic test_slow_ready();
        bit aw_ok;
        bit w_ok;
        bit ar_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        ar_ok = 1'b0;
        awaddr <= A_TWO;
        wdata <= 32'h2a;
        wstrb <= 4'h1;
        araddr <= A_ONE;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        arvalid <= 1'h1;
        while (!(aw_ok && w_ok && ar_ok)) begin
            @(posedge clk_sys);
            if (!aw_ok && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'h0;
            end
            if (!w_ok && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'h0;
            end
            if (!ar_ok && arready) begin
                ar_ok = 1'b1;
                arvalid <= 1'h0;
            end
        end
        while (!(bvalid && rvalid)) begin
            @(posedge clk_sys);
        end
        repeat (2) @(posedge clk_sys);
        chk("bvalid", {31'h0, bvalid}, 32'h1);
        chk("rvalid", {31'h0, rvalid}, 32'h1);
        bready <= 1'h1;
        rready <= 1'h1;
        @(posedge clk_sys);
        chk("bresp", {30'h0, bresp}, {30'h0, lfc_pkg::RESP_OKAY});
        chk("rdata", rdata, 32'h3f);
        bready <= 1'h0;
        rready <= 1'h0;
        @(posedge clk_sys);
        cfg(7'h3f, 7'h2a);
    endtask

    // Reset in mid-run brings both registers back to their power-on words
    task automatic test_reset_again();
        rst_n <= 1'h0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        cfg(7'h27, 7'h27);
        rd(A_ONE, 32'h27, lfc_pkg::RESP_OKAY);
        rd(A_TWO, 32'h27, lfc_pkg::RESP_OKAY);
    endtask

    // Report counts and the verdict, then stop
    task automatic finish_test();
        $display("Checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Reset for six cycles, then run every scenario
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(posedge clk_sys);
        test_reset();
        test_write_max();
        test_write_min();
        test_refused();
        test_slow_ready();
        test_reset_again();
        finish_test();
    end

    // Watchdog at 2000 cycles, well beyond the few dozen cycles the scenarios need
    initial begin
        #50000;
        fail_count++;
        finish_test();
    end
endmodule // lfc_regs_test
